//--- hw/char_fifo.sv
// Flip-flop character FIFO; top entry is shown without a pop
// Assumes the owner never pushes when full nor pops when empty
`timescale 1ns/1ns
`default_nettype none
module char_fifo
  import uart_sc_pkg::*;
#(
  parameter int W = 11,
  parameter int D = FIFO_DEPTH
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  fifo_if.mem f
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] rd_ff;
  logic [AW-1:0] wr_ff;
  logic [AW:0] cnt_ff;

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  // Data array, no reset needed
  always_ff @(posedge clk_sys_i)
  begin
    if (f.push)
      mem_ff[wr_ff] <= f.wdata;
  end

  // Pointers; flush wins over any push or pop
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || f.flush)
    begin
      rd_ff <= '0;
      wr_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (f.push)
        wr_ff <= wr_ff + 1'b1;
      if (f.pop)
        rd_ff <= rd_ff + 1'b1;
      cnt_ff <= cnt_ff + {{AW{1'b0}}, f.push} - {{AW{1'b0}}, f.pop};
    end
  end

  assign f.rdata = mem_ff[rd_ff];
  assign f.count = cnt_ff;
endmodule
`default_nettype wire

//--- hw/uart_status_control.sv
// Serial transceiver status/control core with APB registers and FIFOs
// Assumes a 32-bit APB master and rx line already synchronous to clk
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module uart_status_control
  import uart_sc_pkg::*;
#(
  parameter int OVS = 16
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_i,
  output logic tx_pin_o,
  output logic tx_pin_oe_n_o,
  output logic irq_o
);
  localparam int CW = 11; // data 9, parity err, framing err
  localparam int CNTW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [CNTW-1:0] FULL_CNT = CNTW'(FIFO_DEPTH);
  localparam logic [CNTW-1:0] Q3_CNT = CNTW'(3);
  localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
  localparam logic [3:0] OVS_MID = 4'(OVS / 2 - 1);

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_STOP = 3'b100
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_BITS = 3'b010,
    RX_STOP = 3'b100
  } rx_state_t;

  fifo_if #(.W(CW), .D(FIFO_DEPTH)) txf();
  fifo_if #(.W(CW), .D(FIFO_DEPTH)) rxf();

  // Four-deep buffers in each direction
  char_fifo #(.W(CW), .D(FIFO_DEPTH)) u_txf
  (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .f(txf.mem)
  );
  char_fifo #(.W(CW), .D(FIFO_DEPTH)) u_rxf
  (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .f(rxf.mem)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0] tx_irq_select_ff;
  logic [1:0] rx_irq_select_ff;
  logic tx_break_request_ff;
  logic tx_enable_bit_ff;
  logic address_detect_enable_ff;
  logic overrun_flag_ff;
  logic [1:0] parity_data_select_ff;
  logic [15:0] baud_div_ff;
  logic [IRQ_W-1:0] irq_st_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [31:0] prdata_ff;
  logic brk_ff;

  logic wr_acc, rd_acc, mapped;
  logic [15:0] sta_word;
  logic tx_buffer_full, tx_idle_flag, rx_idle_flag, rx_data_available;
  logic tx_load, tx_done, rx_store, rx_ovf, ovr_clear;
  logic ev_tx, ev_rx, ev_err;
  tx_state_t tx_st_ff;
  rx_state_t rx_st_ff;

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;
  assign pready_o = 1'b1; // Zero wait states
  assign mapped = is_addr(paddr_i, OFS_STA) || is_addr(paddr_i, OFS_MODE) ||
    is_addr(paddr_i, OFS_TXD) || is_addr(paddr_i, OFS_RXD) ||
    is_addr(paddr_i, OFS_BAUD) || is_addr(paddr_i, OFS_IRQ_ST) ||
    is_addr(paddr_i, OFS_IRQ_MASK);
  assign pslverr_o = psel_i && penable_i && !mapped;

  // Status flags
  assign tx_buffer_full = txf.count == FULL_CNT;
  assign tx_idle_flag = tx_st_ff == TX_IDLE && txf.count == '0;
  assign rx_idle_flag = rx_st_ff == RX_IDLE;
  assign rx_data_available = rxf.count != '0;

  always_comb
  begin
    sta_word = '0;
    sta_word[B_TXISEL1] = tx_irq_select_ff[1];
    sta_word[B_TXISEL0] = tx_irq_select_ff[0];
    sta_word[B_BRK] = tx_break_request_ff;
    sta_word[B_TXEN] = tx_enable_bit_ff;
    sta_word[B_TXBF] = tx_buffer_full;
    sta_word[B_TXIDLE] = tx_idle_flag;
    sta_word[B_RXISEL +: 2] = rx_irq_select_ff;
    sta_word[B_ADDRESS_DETECT_ENABLE] = address_detect_enable_ff;
    sta_word[B_RX_IDLE_FLAG] = rx_idle_flag;
    sta_word[B_PARITY_ERROR_FLAG] = rx_data_available && rxf.rdata[9];
    sta_word[B_FRAMING_ERROR_FLAG] = rx_data_available && rxf.rdata[10];
    sta_word[B_OVR] = overrun_flag_ff;
    sta_word[B_RXDA] = rx_data_available;
  end

  // Software fields
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      tx_irq_select_ff <= 2'h0;
      rx_irq_select_ff <= 2'h0;
      tx_enable_bit_ff <= 1'b0;
      address_detect_enable_ff <= 1'b0;
    end
    else if (wr_acc && is_addr(paddr_i, OFS_STA))
    begin
      tx_irq_select_ff <= {pwdata_i[B_TXISEL1], pwdata_i[B_TXISEL0]};
      rx_irq_select_ff <= pwdata_i[B_RXISEL +: 2];
      tx_enable_bit_ff <= pwdata_i[B_TXEN];
      address_detect_enable_ff <= pwdata_i[B_ADDRESS_DETECT_ENABLE];
    end
  end

  // Break request: software sets, hardware clears
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      tx_break_request_ff <= 1'b0;
    else if (wr_acc && is_addr(paddr_i, OFS_STA) && pwdata_i[B_BRK] &&
      pwdata_i[B_TXEN])
      tx_break_request_ff <= 1'b1;
    else if (!tx_enable_bit_ff || (tx_done && brk_ff))
      tx_break_request_ff <= 1'b0;
  end

  // Overrun: software may only clear; a set in the same cycle wins
  assign ovr_clear = wr_acc && is_addr(paddr_i, OFS_STA) &&
    !pwdata_i[B_OVR] && overrun_flag_ff;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      overrun_flag_ff <= 1'b0;
    else if (rx_ovf)
      overrun_flag_ff <= 1'b1;
    else if (ovr_clear)
      overrun_flag_ff <= 1'b0;
  end

  // Mode and baud registers
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      parity_data_select_ff <= 2'h0;
      baud_div_ff <= BAUD_RST;
    end
    else if (wr_acc && is_addr(paddr_i, OFS_MODE))
      parity_data_select_ff <= pwdata_i[1:0];
    else if (wr_acc && is_addr(paddr_i, OFS_BAUD))
      baud_div_ff <= pwdata_i[15:0];
  end

  // Interrupt mask
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      irq_mask_ff <= '0;
    else if (wr_acc && is_addr(paddr_i, OFS_IRQ_MASK))
      irq_mask_ff <= pwdata_i[IRQ_W-1:0];
  end

  // Sticky events; read clears, a new event in that cycle survives
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      irq_st_ff <= '0;
    else if (psel_i && !penable_i && !pwrite_i &&
      is_addr(paddr_i, OFS_IRQ_ST))
      irq_st_ff <= {ev_err, ev_rx, ev_tx};
    else
      irq_st_ff <= irq_st_ff | {ev_err, ev_rx, ev_tx};
  end
  assign irq_o = |(irq_st_ff & irq_mask_ff);

  // Read data, registered; reserved bits read zero
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      prdata_ff <= '0;
    else if (psel_i && !penable_i && !pwrite_i)
    begin
      prdata_ff <= '0;
      if (is_addr(paddr_i, OFS_STA))
        prdata_ff <= {16'h0000, sta_word};
      else if (is_addr(paddr_i, OFS_MODE))
        prdata_ff <= {30'h0, parity_data_select_ff};
      else if (is_addr(paddr_i, OFS_RXD))
        prdata_ff <= {23'h0, rxf.rdata[8:0]};
      else if (is_addr(paddr_i, OFS_BAUD))
        prdata_ff <= {16'h0000, baud_div_ff};
      else if (is_addr(paddr_i, OFS_IRQ_ST))
        prdata_ff <= {29'h0, irq_st_ff};
      else if (is_addr(paddr_i, OFS_IRQ_MASK))
        prdata_ff <= {29'h0, irq_mask_ff};
    end
  end
  assign prdata_o = prdata_ff;

  // ----------------------------------------------------------------
  // Baud tick: one enable per oversample period
  // ----------------------------------------------------------------
  logic [15:0] div_ff;
  logic tick;
  assign tick = div_ff == '0;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || tick)
      div_ff <= baud_div_ff / 16'(OVS);
    else
      div_ff <= div_ff - 1'b1;
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic [12:0] tsh_ff;
  logic [3:0] tbit_ff;
  logic [3:0] tph_ff;
  logic tline_ff;
  logic [3:0] tlen;
  logic [8:0] tword;
  logic tpar;

  // Tx FIFO fill while enabled and not full
  assign txf.push = wr_acc && is_addr(paddr_i, OFS_TXD) &&
    tx_enable_bit_ff && !tx_buffer_full;
  assign txf.wdata = {2'b00, pwdata_i[8:0]};
  assign txf.flush = !tx_enable_bit_ff;
  assign tx_load = tx_st_ff == TX_IDLE && tx_enable_bit_ff &&
    (txf.count != '0 || tx_break_request_ff);
  assign txf.pop = tx_load && !tx_break_request_ff;
  assign tx_done = tx_st_ff == TX_STOP && tick && tph_ff == OVS_LAST;

  // Frame build per data mode
  always_comb
  begin
    tword = txf.rdata[8:0];
    tpar = ^txf.rdata[7:0];
    tlen = 4'd8;
    if (parity_data_select_ff == PD_9BIT)
      tlen = 4'd9;
    else if (parity_data_select_ff == PD_EVEN)
    begin
      tword[8] = tpar;
      tlen = 4'd9;
    end
    else if (parity_data_select_ff == PD_ODD)
    begin
      tword[8] = !tpar;
      tlen = 4'd9;
    end
  end

  // Shifter; disable aborts any frame in flight
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || !tx_enable_bit_ff)
    begin
      tx_st_ff <= TX_IDLE;
      tsh_ff <= '0;
      tbit_ff <= '0;
      tph_ff <= '0;
      brk_ff <= 1'b0;
      tline_ff <= 1'b1;
    end
    else
      unique case (tx_st_ff)
        TX_IDLE:
          if (tx_load)
          begin
            brk_ff <= tx_break_request_ff;
            // Start bit then data or twelve zeros
            tsh_ff <= tx_break_request_ff ? 13'h0000 : {3'b000, tword, 1'b0};
            tbit_ff <= tx_break_request_ff ? 4'(BRK_ZEROS) : tlen;
            tph_ff <= '0;
            tline_ff <= 1'b0;
            tx_st_ff <= TX_SHIFT;
          end
        TX_SHIFT:
          if (tick)
          begin
            tph_ff <= tph_ff + 1'b1;
            if (tph_ff == OVS_LAST)
            begin
              tsh_ff <= {1'b0, tsh_ff[12:1]};
              tline_ff <= tsh_ff[1];
              if (tbit_ff == '0)
              begin
                tline_ff <= 1'b1;
                tx_st_ff <= TX_STOP;
              end
              tbit_ff <= tbit_ff - 1'b1;
            end
          end
        TX_STOP:
          if (tick)
          begin
            tph_ff <= tph_ff + 1'b1;
            if (tph_ff == OVS_LAST)
            begin
              brk_ff <= 1'b0;
              tx_st_ff <= TX_IDLE;
            end
          end
      endcase
  end

  // Pin ownership follows the enable
  assign tx_pin_o = tx_enable_bit_ff ? tline_ff : 1'b1;
  assign tx_pin_oe_n_o = !tx_enable_bit_ff;

  // Transmit interrupt selection
  always_comb
  begin
    ev_tx = 1'b0;
    unique case (tx_irq_select_ff)
      TXI_EMPTY: ev_tx = txf.pop && txf.count == CNTW'(1);
      TXI_DONE: ev_tx = tx_done && txf.count == '0;
      2'h0: ev_tx = txf.pop;
      default: ev_tx = 1'b0; // Reserved code never fires
    endcase
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic [8:0] rsh_ff;
  logic [3:0] rbit_ff;
  logic [3:0] rph_ff;
  logic [3:0] rlen;
  logic rpar_err, rkeep;

  assign rlen = parity_data_select_ff == 2'h0 ? 4'd8 : 4'd9;
  // Sampling at mid-bit
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || ovr_clear)
    begin
      rx_st_ff <= RX_IDLE;
      rsh_ff <= '0;
      rbit_ff <= '0;
      rph_ff <= '0;
    end
    else if (tick)
      unique case (rx_st_ff)
        RX_IDLE:
          if (!rx_i)
          begin
            rph_ff <= '0;
            rbit_ff <= '0;
            rx_st_ff <= RX_BITS;
          end
        RX_BITS:
        begin
          rph_ff <= rph_ff + 1'b1;
          if (rph_ff == OVS_MID && rbit_ff == '0 && rx_i)
            rx_st_ff <= RX_IDLE; // False start
          if (rph_ff == OVS_LAST)
          begin
            rbit_ff <= rbit_ff + 1'b1;
            if (rbit_ff == rlen)
              rx_st_ff <= RX_STOP;
          end
          if (rph_ff == OVS_MID && rbit_ff != '0)
            rsh_ff <= {rx_i, rsh_ff[8:1]};
        end
        RX_STOP:
        begin
          rph_ff <= rph_ff + 1'b1;
          if (rph_ff == OVS_MID)
            rx_st_ff <= RX_IDLE;
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
  end

  // Store at the stop sample, whose level sets the framing bit; 8-bit data is right aligned
  always_comb
  begin
    rpar_err = 1'b0;
    if (parity_data_select_ff == PD_EVEN)
      rpar_err = ^rsh_ff;
    else if (parity_data_select_ff == PD_ODD)
      rpar_err = !(^rsh_ff);
    rkeep = !(address_detect_enable_ff &&
      parity_data_select_ff == PD_9BIT && !rsh_ff[8]);
  end
  assign rx_store = tick && rx_st_ff == RX_STOP && rph_ff == OVS_MID && rkeep;
  assign rx_ovf = rx_store && rxf.count == FULL_CNT;
  assign rxf.push = rx_store && !rx_ovf;
  assign rxf.wdata = {!rx_i, rpar_err,
    parity_data_select_ff == PD_9BIT ? rsh_ff :
    rlen == 4'd9 ? {1'b0, rsh_ff[7:0]} : {1'b0, rsh_ff[8:1]}};
  assign rxf.pop = rd_acc && is_addr(paddr_i, OFS_RXD) &&
    rx_data_available;
  assign rxf.flush = ovr_clear;

  // Receive and error interrupt selection
  always_comb
  begin
    ev_rx = 1'b0;
    unique case (rx_irq_select_ff)
      RXI_FULL: ev_rx = rxf.push && rxf.count == FULL_CNT - 1'b1;
      RXI_3Q: ev_rx = rxf.push && rxf.count == Q3_CNT - 1'b1;
      default: ev_rx = rxf.push;
    endcase
    ev_err = rx_ovf || (rxf.push && (rxf.wdata[9] || rxf.wdata[10]));
  end
endmodule
`default_nettype wire

//--- shared/fifo_if.sv
// Push/pop bundle between the control block and one character FIFO
// Assumes a single clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface fifo_if #(parameter int W = 11, parameter int D = 4);
  logic push;
  logic pop;
  logic flush;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic [$clog2(D):0] count;
  modport ctl (output push, pop, flush, wdata, input rdata, count);
  modport mem (input push, pop, flush, wdata, output rdata, count);
endinterface
`default_nettype wire

//--- shared/uart_sc_pkg.sv
// Constants for the serial status/control block: register map, fields, codes
// Assumes a 32-bit APB master and a 50 MHz system clock
// Functional notes
// - tx irq select: 11 reserved, 10 buffer empties, 01 all shifted, 00 every character popped to the shifter
// - Break request sends start, twelve zeros, stop; hardware clears it after
// - Tx enable drives the pin; clearing aborts, flushes buffer, releases the pin
// - Tx buffer full reads 1 when no further character fits
// - Tx idle reads 1 only with shifter and buffer empty; resets to 1
// - rx irq select: 11 buffer full, 10 three held, 0x every character
// - Address detect in 9-bit mode keeps only characters with ninth bit one
// - Rx idle reads 1 when no character is arriving; resets to 1
// - Parity error flag belongs to the character at the rx FIFO top
// - Framing error flag belongs to the character at the rx FIFO top
// - Overrun set on overflow; software clear flushes rx buffer and shifter
// - Rx data available reads 1 while the rx buffer holds a character
// - Parity/data select 11 is 9-bit no parity; others 8-bit none/even/odd
// - Transmit and receive each have a four-character FIFO
package uart_sc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STA = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_TXD = 8'h08;
  localparam logic [7:0] OFS_RXD = 8'h0c;
  localparam logic [7:0] OFS_BAUD = 8'h10;
  localparam logic [7:0] OFS_IRQ_ST = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // ----------------------------------------------------------------
  // Status/control field positions
  // ----------------------------------------------------------------
  localparam int B_TXISEL1 = 15;
  localparam int B_TXISEL0 = 13;
  localparam int B_BRK = 11;
  localparam int B_TXEN = 10;
  localparam int B_TXBF = 9;
  localparam int B_TXIDLE = 8;
  localparam int B_RXISEL = 6;
  localparam int B_ADDRESS_DETECT_ENABLE = 5;
  localparam int B_RX_IDLE_FLAG = 4;
  localparam int B_PARITY_ERROR_FLAG = 3;
  localparam int B_FRAMING_ERROR_FLAG = 2;
  localparam int B_OVR = 1;
  localparam int B_RXDA = 0;
  // Mode register: parity/data select in bits 1:0
  localparam logic [1:0] PD_9BIT = 2'h3;
  localparam logic [1:0] PD_ODD = 2'h2;
  localparam logic [1:0] PD_EVEN = 2'h1;
  // Interrupt status bits
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_W = 3;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] BAUD_RST = 16'h01b1; // 50 MHz / 115200, less one
  localparam int FIFO_DEPTH = 4;
  localparam int BRK_ZEROS = 12;
  localparam int CHAR_BITS = 9;
  localparam logic [1:0] TXI_EMPTY = 2'h2;
  localparam logic [1:0] TXI_DONE = 2'h1;
  localparam logic [1:0] RXI_FULL = 2'h3;
  localparam logic [1:0] RXI_3Q = 2'h2;
endpackage

//--- testbench/serial_peer.sv
// Remote serial peer: sends frames on rx, samples frames from tx
// Assumes BIT clocks per bit, set to match the baud divisor
`timescale 1ns/1ns
`default_nettype none
module serial_peer #(
  parameter int BIT = 16
)
(
  input wire logic clk_i,
  input wire logic tx_i,
  input wire logic tx_oe_n_i,
  output logic rx_o
);
  // ----------------------------------------------------------------
  // Line state and capture
  // ----------------------------------------------------------------
  int run = 0;
  int last_run = 0;
  logic [8:0] cap;
  logic [7:0] got_q[$];
  initial
    rx_o = 1'b1;
  // Low-run meter for breaks
  always @(posedge clk_i)
    if (!tx_i)
      run <= run + 1;
    else
    begin
      if (run != 0)
        last_run <= run;
      run <= 0;
    end
  // Mid-bit sampling of data and stop
  always @(negedge tx_i)
    if (!tx_oe_n_i)
    begin
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 9; i++)
      begin
        repeat (BIT) @(posedge clk_i);
        cap[i] = tx_i;
      end
      got_q.push_back(cap[7:0]);
    end
  // Frame out LSB first; stop level is a parameter
  task automatic send(input logic [8:0] d, input int n, input logic stopv);
    rx_o <= 1'b0;
    repeat (BIT) @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      rx_o <= d[i];
      repeat (BIT) @(posedge clk_i);
    end
    rx_o <= stopv;
    repeat (BIT) @(posedge clk_i);
    rx_o <= 1'b1;
    repeat (2 * BIT) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- testbench/uart_sc_sva.sv
// Checker for the serial status/control block, bound to its top module
// Assumes zero-wait APB and one system clock
`timescale 1ns/1ns
`default_nettype none
module uart_sc_sva
  import uart_sc_pkg::*;
#(
  parameter int OVS = 16
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic rx_i,
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe_n_o,
  input wire logic irq_o
);
  // ----------------------------------------------------------------
  // Decoded bus phases
  // ----------------------------------------------------------------
  logic acc, bad, sta_wr, sta_rd;
  assign acc = psel_i && penable_i;
  assign bad = (paddr_i > OFS_IRQ_MASK) || (paddr_i[1:0] != 2'h0);
  assign sta_wr = acc && pwrite_i && (paddr_i == OFS_STA);
  assign sta_rd = psel_i && !penable_i && !pwrite_i && (paddr_i == OFS_STA);
  // One clock domain
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_READY: assert property (acc |-> pready_o)
    else $error("no ready in access phase");
  AST_SLVERR: assert property (pslverr_o == (acc && bad))
    else $error("error response wrong");
  AST_BAD_RD: assert property (psel_i && !penable_i && !pwrite_i && bad
    |=> prdata_o == 32'h0) else $error("unmapped read not zero");
  AST_TX_OFF: assert property (
    sta_wr && !pwdata_i[B_TXEN] |=> tx_pin_oe_n_o && tx_pin_o)
    else $error("pin kept after disable");
  AST_TX_ON: assert property (
    sta_wr && pwdata_i[B_TXEN] |=> !tx_pin_oe_n_o)
    else $error("pin not taken on enable");
  AST_PIN_IDLE: assert property (tx_pin_oe_n_o |-> tx_pin_o)
    else $error("released pin not high");
  AST_FULL_IDLE: assert property (
    sta_rd |=> !(prdata_o[B_TXBF] && prdata_o[B_TXIDLE]))
    else $error("full and idle together");
  // Shortest bit is 16 clocks, so a low level lasts at least 8
  AST_START: assert property (
    $fell(tx_pin_o) |-> (!tx_pin_o || tx_pin_oe_n_o) [*8])
    else $error("line low pulse too short");
  AST_IRQ_OFF: assert property (acc && pwrite_i
    && paddr_i == OFS_IRQ_MASK && pwdata_i[2:0] == 3'h0 |=> !irq_o)
    else $error("irq with all masked");
  C_IRQ: cover property ($rose(irq_o));
  C_TX: cover property ($fell(tx_pin_o));
  C_BAD: cover property (acc && bad);
endmodule
bind uart_status_control uart_sc_sva #(.OVS(OVS)) u_sva (.*);
`default_nettype wire

//--- testbench/uart_status_control_tb.sv
// Self-checking bench for the serial status/control block
// Assumes the peer model and bound checker
`timescale 1ns/1ns
`default_nettype none
module uart_status_control_tb
  import uart_sc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals, clock, instances
  // ----------------------------------------------------------------
  localparam int BIT = 16; // baud divisor 0 gives 16 clocks per bit
  logic clk, rst_n, psel, penable, pwrite, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, rx, tx, tx_oe_n, irq;
  int num_errors = 0;
  int n_compared = 0;
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  uart_status_control dut (.clk_sys_i(clk), .rst_n_i(rst_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rx_i(rx), .tx_pin_o(tx),
    .tx_pin_oe_n_o(tx_oe_n), .irq_o(irq));
  serial_peer #(.BIT(BIT)) peer (.clk_i(clk), .tx_i(tx),
    .tx_oe_n_i(tx_oe_n), .rx_o(rx));
  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic chb(input logic s, input logic e);
    chk(32'(s), 32'(e));
  endtask
  // Ends on an idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_tx(input int n);
    while (peer.got_q.size() < n)
      @(posedge clk);
    repeat (2 * BIT) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_STA);
    chk(q, 32'h0000_0110);
    rd(8'h1c);
    chk(q, 32'h0);
    chb(se, 1'b1);
    wr(8'h20, 32'hffff_ffff);
    chb(se, 1'b1);
    wr(OFS_BAUD, 32'h0);
    wr(OFS_IRQ_MASK, 32'h7);
  endtask
  // Six writes: one to the shifter, four queued, the last dropped
  task automatic t_tx;
    for (int c = 0; c < 3; c++)
    begin
      peer.got_q.delete();
      rd(OFS_IRQ_ST);
      wr(OFS_STA, 32'h0400 | (c[1] << B_TXISEL1) | (c[0] << B_TXISEL0));
      for (int i = 0; i < (c == 2 ? 6 : 1); i++)
        wr(OFS_TXD, 32'h41 + i);
      rd(OFS_STA);
      chb(q[B_TXBF], c == 2);
      chb(q[B_TXIDLE], 1'b0);
      wait_tx(c == 2 ? 5 : 1);
      chk(peer.got_q.size(), c == 2 ? 5 : 1);
      chk({24'h0, peer.got_q[0]}, 32'h41);
      chb(irq, 1'b1);
      rd(OFS_IRQ_ST);
      chb(q[IRQ_TX], 1'b1);
      rd(OFS_STA);
      chb(q[B_TXIDLE], 1'b1);
    end
    chk({24'h0, peer.got_q[4]}, 32'h45);
  endtask
  task automatic t_rx;
    int n;
    for (int c = 0; c < 4; c++)
    begin
      wr(OFS_STA, 32'h0400 | (c << B_RXISEL));
      rd(OFS_IRQ_ST);
      n = (c == 3) ? 4 : (c == 2) ? 3 : 1;
      for (int k = 1; k <= n; k++)
      begin
        fork
          peer.send(9'(k), 8, 1'b1);
          begin
            repeat (3 * BIT) @(posedge clk);
            rd(OFS_STA);
            chb(q[B_RX_IDLE_FLAG], 1'b0);
          end
        join
        rd(OFS_IRQ_ST);
        chb(q[IRQ_RX], k == n);
      end
      for (int k = 1; k <= n; k++)
      begin
        rd(OFS_RXD);
        chk(q & 32'h1ff, 32'(k));
      end
      rd(OFS_STA);
      chb(q[B_RXDA], 1'b0);
      chb(q[B_RX_IDLE_FLAG], 1'b1);
    end
  endtask
  // Bad entry then good: flags follow the top
  task automatic t_err;
    peer.send(9'h03c, 8, 1'b0);
    peer.send(9'h05a, 8, 1'b1);
    rd(OFS_STA);
    chb(q[B_FRAMING_ERROR_FLAG], 1'b1);
    rd(OFS_RXD);
    chk(q & 32'h1ff, 32'h3c);
    rd(OFS_STA);
    chb(q[B_FRAMING_ERROR_FLAG], 1'b0);
    rd(OFS_RXD);
    wr(OFS_MODE, 32'(PD_EVEN));
    peer.send(9'h10f, 9, 1'b1);
    peer.send(9'h101, 9, 1'b1);
    rd(OFS_STA);
    chb(q[B_PARITY_ERROR_FLAG], 1'b1);
    rd(OFS_RXD);
    rd(OFS_STA);
    chb(q[B_PARITY_ERROR_FLAG], 1'b0);
    rd(OFS_RXD);
    chk(q & 32'hff, 32'h01);
  endtask
  task automatic t_ovr;
    wr(OFS_MODE, 32'h0);
    for (int k = 0; k < 6; k++)
      peer.send(9'(k), 8, 1'b1);
    rd(OFS_STA);
    chb(q[B_OVR], 1'b1);
    wr(OFS_STA, 32'h0400);
    rd(OFS_STA);
    chk(q & 32'h3, 32'h0);
    peer.send(9'h077, 8, 1'b1);
    rd(OFS_RXD);
    chk(q & 32'h1ff, 32'h77);
  endtask
  task automatic t_addr;
    wr(OFS_MODE, 32'(PD_9BIT));
    wr(OFS_STA, 32'h0400 | (1 << B_ADDRESS_DETECT_ENABLE));
    peer.send(9'h055, 9, 1'b1);
    peer.send(9'h1aa, 9, 1'b1);
    rd(OFS_RXD);
    chk(q & 32'h1ff, 32'h1aa);
    rd(OFS_STA);
    chb(q[B_RXDA], 1'b0);
    wr(OFS_MODE, 32'h0);
    peer.send(9'h055, 8, 1'b1);
    rd(OFS_RXD);
    chk(q & 32'h1ff, 32'h55);
  endtask
  // Abort mid-frame, then a break
  task automatic t_abort_brk;
    wr(OFS_TXD, 32'h99);
    repeat (3 * BIT) @(posedge clk);
    wr(OFS_STA, 32'h0);
    chb(tx, 1'b1);
    chb(tx_oe_n, 1'b1);
    rd(OFS_STA);
    chk(q & 32'h300, 32'h100);
    repeat (12 * BIT) @(posedge clk);
    wr(OFS_STA, 32'h0c00);
    repeat (16 * BIT) @(posedge clk);
    chk(peer.last_run, 13 * BIT);
    rd(OFS_STA);
    chb(q[B_BRK], 1'b0);
    wr(OFS_IRQ_MASK, 32'h0);
    chb(irq, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // Sequence, watchdog, verdict
  // ----------------------------------------------------------------
  task automatic give_verdict;
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_tx();
    t_rx();
    t_err();
    t_ovr();
    t_addr();
    t_abort_brk();
    give_verdict();
  end
  // Run is near 6.5k clocks
  initial
  begin
    repeat (80000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
